// ---- design/spims_port.sv ----
`timescale 1ns/1ps
// What this block does
// - phase zero samples leading, else trailing
// - drive and capture on opposite edges
// - polarity and phase form modes 0-3
// - rate bits affect master clock only
// - divide by 4/16/64/128, double 2/8/32/64
// - done flag bit 7 raises interrupt request
// - select low in master sets done
// - done clears on vector or status-data
// - data write mid-transfer sets collision bit 6
// - status then data access clears both flags
// - status bits five to one read zero
// - double speed bit halves clock period
// - data write loads shifter, starts transfer as master
// - data read returns receive buffer
// - clock idles at polarity level
// - order bit set sends lsb first
// - slave deselect resets bit count, drops bits
// - select low in master drops to slave
module spims_port (
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_srst,
    // register port
    input  wire logic [1:0] i_addr,
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_wr,
    input  wire logic       i_rd,
    output logic      [7:0] o_rdata,
    // interrupt handshake
    input  wire logic       i_gie,
    input  wire logic       i_irq_ack,
    output logic            o_irq,
    // serial pins
    input  wire logic       i_sck,
    output logic            o_sck,
    output logic            o_sck_oe,
    input  wire logic       i_mosi,
    output logic            o_mosi,
    output logic            o_mosi_oe,
    input  wire logic       i_miso,
    output logic            o_miso,
    output logic            o_miso_oe,
    input  wire logic       i_ss_n,
    input  wire logic       i_ss_is_input
);
    // ****************************************
    // state
    // ****************************************
    typedef enum logic [0:0] {
        SPIMS_IDLE = 1'b0,
        SPIMS_BUSY = 1'b1
    } spims_mode_t;

    typedef struct packed {
        spims_mode_t mode;
        logic [7:0]  ctrl;
        logic        done;
        logic        write_collision_flag;
        logic        dbl;
        logic        armed;
        logic [7:0]  shift;
        logic [7:0]  rxbuf;
        logic [3:0]  edges;
        logic [6:0]  div;
        logic        sck;
        logic        sin;
        logic        sout;
        logic        sck_prev;
        logic [7:0]  rdata;
        logic        irq;
    } spims_state_t;

    spims_state_t s_reg;
    spims_state_t s_next;

    logic       master;
    logic       clock_polarity;
    logic       clock_phase;
    logic       lsb_first;
    logic       enable;
    logic [6:0] half;
    logic       tick;
    logic       lead;
    logic       trail;
    logic       data_acc;
    logic       wr_data;
    logic       slv_sel;
    logic       out_bit;

    assign master    = s_reg.ctrl[spims_pkg::CTRL_MASTER];
    assign clock_polarity      = s_reg.ctrl[spims_pkg::CTRL_CLOCK_POLARITY];
    assign clock_phase      = s_reg.ctrl[spims_pkg::CTRL_CLOCK_PHASE];
    assign lsb_first = s_reg.ctrl[spims_pkg::CTRL_ORDER];
    assign enable    = s_reg.ctrl[spims_pkg::CTRL_ENABLE];
    assign data_acc  = (i_wr || i_rd) && i_addr == spims_pkg::ADDR_DATA;
    assign wr_data   = i_wr && i_addr == spims_pkg::ADDR_DATA;
    assign slv_sel   = enable && !master && !i_ss_n;
    assign out_bit   = lsb_first ? s_reg.shift[0] : s_reg.shift[7];

    // divider half period, ignored by a slave
    always_comb begin
        case ({s_reg.dbl, s_reg.ctrl[spims_pkg::CTRL_RATE_HI], s_reg.ctrl[spims_pkg::CTRL_RATE_LO]})
            3'h0:    half = spims_pkg::HALF_DIV4;
            3'h1:    half = spims_pkg::HALF_DIV16;
            3'h2:    half = spims_pkg::HALF_DIV64;
            3'h3:    half = spims_pkg::HALF_DIV128;
            3'h4:    half = spims_pkg::HALF_DIV2;
            3'h5:    half = spims_pkg::HALF_DIV8;
            3'h6:    half = spims_pkg::HALF_DIV32;
            default: half = spims_pkg::HALF_DIV64;
        endcase
    end

    // ****************************************
    // edge detection
    // ****************************************
    // slave clock is taken as synchronous; the quarter-rate limit keeps edges apart
    always_comb begin
        tick  = master && s_reg.mode == SPIMS_BUSY && s_reg.div == half;
        lead  = 1'b0;
        trail = 1'b0;
        if (master) begin
            lead  = tick && (s_reg.sck == clock_polarity);
            trail = tick && (s_reg.sck != clock_polarity);
        end else if (slv_sel) begin
            lead  = (i_sck != s_reg.sck_prev) && (i_sck != clock_polarity);
            trail = (i_sck != s_reg.sck_prev) && (i_sck == clock_polarity);
        end
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_next          = s_reg;
        s_next.sck_prev = i_sck;
        s_next.rdata    = 8'h00;
        // register reads, one cycle late
        if (i_rd) begin
            case (i_addr)
                spims_pkg::ADDR_CTRL:   s_next.rdata = s_reg.ctrl;
                spims_pkg::ADDR_STATUS: s_next.rdata = {s_reg.done, s_reg.write_collision_flag, 5'h00, s_reg.dbl};
                spims_pkg::ADDR_DATA:   s_next.rdata = s_reg.rxbuf;
                default:                s_next.rdata = 8'h00;
            endcase
        end
        // flag clearing by status then data access
        if (i_rd && i_addr == spims_pkg::ADDR_STATUS && (s_reg.done || s_reg.write_collision_flag)) begin
            s_next.armed = 1'b1;
        end
        if (data_acc && s_reg.armed) begin
            s_next.done  = 1'b0;
            s_next.write_collision_flag  = 1'b0;
            s_next.armed = 1'b0;
        end
        if (i_irq_ack) begin
            s_next.done = 1'b0;
        end
        if (i_wr && i_addr == spims_pkg::ADDR_CTRL) begin
            s_next.ctrl = i_wdata;
        end
        if (i_wr && i_addr == spims_pkg::ADDR_STATUS) begin
            s_next.dbl = i_wdata[spims_pkg::STAT_DBL];
        end
        // data write: start or collide
        if (wr_data && enable) begin
            if (s_reg.mode == SPIMS_BUSY) begin
                s_next.write_collision_flag = 1'b1;
            end else begin
                s_next.shift = i_wdata;
                s_next.edges = 4'h0;
                s_next.div   = 7'h00;
                s_next.sout  = lsb_first ? i_wdata[0] : i_wdata[7];
                if (master) begin
                    s_next.mode = SPIMS_BUSY;
                end
            end
        end
        // slave becomes busy on its first edge while selected
        if (slv_sel && (lead || trail) && s_reg.mode == SPIMS_IDLE) begin
            s_next.mode = SPIMS_BUSY;
        end
        if (master && s_reg.mode == SPIMS_BUSY) begin
            s_next.div = tick ? 7'h00 : s_reg.div + 7'h01;
            if (tick) begin
                s_next.sck = ~s_reg.sck;
            end
        end
        // shifting: sample on one edge, change on the other
        if (s_reg.mode == SPIMS_BUSY || slv_sel) begin
            if ((lead && !clock_phase) || (trail && clock_phase)) begin
                s_next.sin = master ? i_miso : i_mosi;
            end
            if ((trail && !clock_phase) || (lead && clock_phase)) begin
                s_next.edges = s_reg.edges; // shift happens below
            end
            if (lead || trail) begin
                s_next.edges = s_reg.edges + 4'h1;
            end
            // commit sampled bit at each sample edge into shift register
            if ((lead && !clock_phase) || (trail && clock_phase)) begin
                s_next.shift = lsb_first ? {(master ? i_miso : i_mosi), s_reg.shift[7:1]}
                                         : {s_reg.shift[6:0], (master ? i_miso : i_mosi)};
            end
            if ((trail && !clock_phase) || (lead && clock_phase)) begin
                s_next.sout = out_bit;
            end
            if (lead && clock_phase) begin
                s_next.sout = out_bit;
            end
            if ((lead || trail) && s_reg.edges == 4'(2 * spims_pkg::BITS_PER_XFER - 1)) begin
                s_next.mode  = SPIMS_IDLE;
                s_next.done  = 1'b1;
                s_next.edges = 4'h0;
                s_next.rxbuf = ((lead && !clock_phase) || (trail && clock_phase)) ? s_next.shift : s_reg.shift;
            end
        end
        // slave deselect drops a partial byte
        if (!master && i_ss_n && s_reg.mode == SPIMS_BUSY) begin
            s_next.mode  = SPIMS_IDLE;
            s_next.edges = 4'h0;
        end
        // another master selects us
        if (enable && master && i_ss_is_input && !i_ss_n) begin
            s_next.ctrl[spims_pkg::CTRL_MASTER] = 1'b0;
            s_next.done  = 1'b1;
            s_next.mode  = SPIMS_IDLE;
            s_next.edges = 4'h0;
        end
        if (s_next.mode == SPIMS_IDLE) begin
            s_next.sck = s_next.ctrl[spims_pkg::CTRL_CLOCK_POLARITY];
        end
        s_next.irq = s_next.done && s_next.ctrl[spims_pkg::CTRL_IRQ_EN] && i_gie;
    end

    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            s_reg      <= '0;
            s_reg.mode <= SPIMS_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    // the data write drives the first bit in either phase; sout holds it
    assign o_rdata   = s_reg.rdata;
    assign o_irq     = s_reg.irq;
    assign o_sck     = s_reg.sck;
    assign o_sck_oe  = enable && master;
    assign o_mosi    = s_reg.sout;
    assign o_mosi_oe = enable && master;
    assign o_miso    = s_reg.sout;
    assign o_miso_oe = enable && !master && !i_ss_n;

    // ****************************************
    // checks
    // ****************************************
    AST_IDLE_LEVEL: assert property (@(posedge i_clk) disable iff (i_srst)
        (s_reg.mode == SPIMS_IDLE && master && $stable(clock_polarity) && $past(s_reg.mode) == SPIMS_IDLE) |-> o_sck == clock_polarity)
        else $error("sck not at idle level");
    AST_WRITE_COLLISION_FLAG_SET: assert property (@(posedge i_clk) disable iff (i_srst)
        (wr_data && enable && s_reg.mode == SPIMS_BUSY) |=> s_reg.write_collision_flag)
        else $error("collision not flagged");
    AST_RESERVED: assert property (@(posedge i_clk) disable iff (i_srst)
        (i_rd && i_addr == spims_pkg::ADDR_STATUS) |=> o_rdata[5:1] == 5'h00)
        else $error("reserved status bits nonzero");
    AST_SS_DROP: assert property (@(posedge i_clk) disable iff (i_srst)
        (enable && master && i_ss_is_input && !i_ss_n) |=> !master && s_reg.done)
        else $error("master not released");
    AST_START: assert property (@(posedge i_clk) disable iff (i_srst)
        (wr_data && enable && master && s_reg.mode == SPIMS_IDLE && !(i_ss_is_input && !i_ss_n))
        |=> s_reg.mode == SPIMS_BUSY && s_reg.shift == $past(i_wdata))
        else $error("transfer not started");
    AST_FAST_TICK: assert property (@(posedge i_clk) disable iff (i_srst)
        (s_reg.mode == SPIMS_BUSY && master && s_reg.dbl && s_reg.ctrl[1:0] == 2'h0 && !i_wr && tick)
        |=> (tick || s_reg.mode == SPIMS_IDLE))
        else $error("double speed period wrong");
    AST_IRQ: assert property (@(posedge i_clk) disable iff (i_srst)
        o_irq |-> $past(s_next.done))
        else $error("irq without done");
    AST_SLAVE_RESET: assert property (@(posedge i_clk) disable iff (i_srst)
        (!master && i_ss_n && s_reg.mode == SPIMS_BUSY) |=> s_reg.mode == SPIMS_IDLE && s_reg.edges == 4'h0)
        else $error("slave not reset on deselect");
endmodule : spims_port

// ---- design/spims_pkg.sv ----
package spims_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [1:0] ADDR_CTRL      = 2'h0;
    localparam logic [1:0] ADDR_STATUS    = 2'h1;
    localparam logic [1:0] ADDR_DATA      = 2'h2;
    // ****************************************
    // control field positions
    // ****************************************
    localparam int         CTRL_IRQ_EN    = 7;
    localparam int         CTRL_ENABLE    = 6;
    localparam int         CTRL_ORDER     = 5;
    localparam int         CTRL_MASTER    = 4;
    localparam int         CTRL_CLOCK_POLARITY      = 3;
    localparam int         CTRL_CLOCK_PHASE      = 2;
    localparam int         CTRL_RATE_HI   = 1;
    localparam int         CTRL_RATE_LO   = 0;
    // ****************************************
    // status field positions and resets
    // ****************************************
    localparam int         STAT_DONE      = 7;
    localparam int         STAT_WRITE_COLLISION_FLAG      = 6;
    localparam int         STAT_DBL       = 0;
    localparam logic [7:0] CTRL_RESET     = 8'h00;
    localparam logic [7:0] STAT_RESET     = 8'h00;
    // ****************************************
    // timing
    // ****************************************
    localparam int         BITS_PER_XFER  = 8;
    localparam logic [6:0] HALF_DIV4      = 7'h01;
    localparam logic [6:0] HALF_DIV16     = 7'h07;
    localparam logic [6:0] HALF_DIV64     = 7'h1F;
    localparam logic [6:0] HALF_DIV128    = 7'h3F;
    localparam logic [6:0] HALF_DIV2      = 7'h00;
    localparam logic [6:0] HALF_DIV8      = 7'h03;
    localparam logic [6:0] HALF_DIV32     = 7'h0F;
endpackage : spims_pkg

// ---- verification/spims_peer.sv ----
`timescale 1ns/1ps
// ****************************************
// far-side serial slave
// ****************************************
module spims_peer (
    // mode and data
    input  wire logic       i_clk,
    input  wire logic       i_sel,
    input  wire logic       i_clock_polarity,
    input  wire logic       i_clock_phase,
    input  wire logic       i_lsb,
    input  wire logic [7:0] i_tx,
    // serial pins
    input  wire logic       i_sck,
    input  wire logic       i_mosi,
    output logic            o_miso,
    output logic      [7:0] o_rx
);
    logic       junk_reg = 1'b0;
    int         shifts   = 0;
    int         setups   = 0;
    // acts on the serial edge itself, so even the fastest clock leaves a full cycle of setup
    always @(i_sck or negedge i_sel) begin
        if (!i_sel) begin
            shifts = 0;
            setups = 0;
        end else if ((i_sck != i_clock_polarity) != i_clock_phase) begin
            o_rx = i_lsb ? {i_mosi, o_rx[7:1]} : {o_rx[6:0], i_mosi};
        end else begin
            if (!i_clock_phase || setups != 0) begin
                shifts = shifts + 1;
            end
            setups = setups + 1;
        end
    end
    always @(posedge i_clk) begin
        junk_reg <= ~junk_reg;
    end
    // deselected line toggles, never a stale bit
    assign o_miso = !i_sel ? junk_reg : (shifts > 7) ? 1'b0 : i_tx[i_lsb ? shifts : 7 - shifts];
endmodule : spims_peer

// ---- verification/tb_spi_master_slave_port.sv ----
`timescale 1ns/1ps
module tb_spi_master_slave_port;
    logic       i_clk         = 1'b0;
    logic       i_srst        = 1'b1;
    logic [1:0] i_addr        = 2'h0;
    logic [7:0] i_wdata       = 8'h00;
    logic       i_wr          = 1'b0;
    logic       i_rd          = 1'b0;
    logic       i_gie         = 1'b0;
    logic       i_irq_ack     = 1'b0;
    logic       i_ss_n        = 1'b1;
    logic       i_ss_is_input = 1'b0;
    logic       tb_sck        = 1'b0;
    logic       tb_mosi       = 1'b0;
    logic       p_sel         = 1'b0;
    logic [7:0] p_ctl         = 8'h00;
    logic [7:0] p_tx          = 8'h00;
    logic [7:0] p_rx, rd_val, o_rdata;
    logic [7:0] s_got         = 8'h00;
    logic       o_irq, o_sck, o_sck_oe, o_mosi, o_mosi_oe, o_miso, o_miso_oe, p_miso;
    int         fail_count    = 0;
    int         compares      = 0;
    int         cycles        = 0;
    int         div [8]       = '{4, 16, 64, 128, 2, 8, 32, 64};
    wire        sck_w         = o_sck_oe ? o_sck : tb_sck;
    wire        mosi_w        = o_mosi_oe ? o_mosi : tb_mosi;
    wire        miso_w        = o_miso_oe ? o_miso : p_miso;
    always #20 i_clk = ~i_clk;
    spims_port dut_u (
        .i_clk, .i_srst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_gie, .i_irq_ack, .o_irq,
        .i_sck(sck_w), .o_sck, .o_sck_oe, .i_mosi(mosi_w), .o_mosi, .o_mosi_oe,
        .i_miso(miso_w), .o_miso, .o_miso_oe, .i_ss_n, .i_ss_is_input
    );
    spims_peer peer_u (
        .i_clk, .i_sel(p_sel), .i_clock_polarity(p_ctl[3]), .i_clock_phase(p_ctl[2]), .i_lsb(p_ctl[5]), .i_tx(p_tx),
        .i_sck(sck_w), .i_mosi(mosi_w), .o_miso(p_miso), .o_rx(p_rx)
    );
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(string name, logic [7:0] exp, logic [7:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic chk_cnt(string name, int exp, int got);
        compares++;
        if (got != exp) begin
            fail_count++;
            $display("MISMATCH %s expected %0d seen %0d", name, exp, got);
        end
    endtask : chk_cnt
    task automatic wr(logic [1:0] a, logic [7:0] d);
        @(posedge i_clk);
        i_addr  <= a;
        i_wdata <= d;
        i_wr    <= 1'b1;
        @(posedge i_clk);
        i_wr    <= 1'b0;
    endtask : wr
    task automatic rd(logic [1:0] a);
        @(posedge i_clk);
        i_addr <= a;
        i_rd   <= 1'b1;
        @(posedge i_clk);
        i_rd   <= 1'b0;
        #1 rd_val = o_rdata;
    endtask : rd
    // polling status also arms the flag-clearing sequence
    task automatic wait_done();
        int n;
        n = 0;
        rd_val = 8'h00;
        while (rd_val[7] !== 1'b1 && n < 3000) begin
            rd(spims_pkg::ADDR_STATUS);
            n++;
        end
        chk("done flag", 8'h80, rd_val & 8'h80);
    endtask : wait_done
    task automatic m_xfer(logic [7:0] ctrl, logic [7:0] tx, logic [7:0] ptx);
        p_ctl = ctrl;
        wr(spims_pkg::ADDR_CTRL, ctrl);
        @(posedge i_clk);
        #1 chk("sck idle", {7'h00, ctrl[3]}, {7'h00, o_sck});
        p_tx  = ptx;
        p_sel = 1'b1;
        wr(spims_pkg::ADDR_DATA, tx);
        wait_done();
        chk("peer rx", tx, p_rx);
        rd(spims_pkg::ADDR_DATA);
        chk("rx data", ptx, rd_val);
        rd(spims_pkg::ADDR_STATUS);
        chk("status cleared", 8'h00, rd_val);
        p_sel = 1'b0;
    endtask : m_xfer
    // mode 0 at clk/9, inside the external clock limit
    task automatic s_bits(logic [7:0] b, int n);
        for (int i = 0; i < n; i++) begin
            @(posedge i_clk);
            tb_mosi <= b[7 - i];
            repeat (4) @(posedge i_clk);
            s_got   <= {s_got[6:0], miso_w};
            tb_sck  <= 1'b1;
            repeat (4) @(posedge i_clk);
            tb_sck  <= 1'b0;
        end
    endtask : s_bits
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs();
        rd(spims_pkg::ADDR_CTRL);
        chk("ctrl reset", spims_pkg::CTRL_RESET, rd_val);
        wr(spims_pkg::ADDR_STATUS, 8'hFF);
        rd(spims_pkg::ADDR_STATUS);
        chk("status reserved", 8'h01, rd_val);
        wr(spims_pkg::ADDR_STATUS, 8'h00);
        wr(2'h3, 8'hFF);
        rd(2'h3);
        chk("unmapped", 8'h00, rd_val);
        $display("test registers done");
    endtask : t_regs
    task automatic t_modes();
        for (int m = 0; m < 8; m++) begin
            m_xfer({2'b01, m[2], 1'b1, m[1:0], 2'b00}, 8'h35 + 8'(m), 8'hC6 ^ 8'(m));
        end
        $display("test modes done");
    endtask : t_modes
    task automatic t_rates();
        logic s;
        int   n;
        for (int r = 0; r < 8; r++) begin
            wr(spims_pkg::ADDR_STATUS, {7'h00, r[2]});
            wr(spims_pkg::ADDR_CTRL, {6'b010100, r[1:0]});
            wr(spims_pkg::ADDR_DATA, 8'h96);
            for (int k = 0; k < 2; k++) begin
                s = o_sck;
                n = 0;
                while (o_sck === s && n < 300) begin
                    @(posedge i_clk);
                    #1 n++;
                end
            end
            chk_cnt("sck half period", div[r] / 2, n);
            wait_done();
            rd(spims_pkg::ADDR_DATA);
        end
        wr(spims_pkg::ADDR_STATUS, 8'h00);
        $display("test rates done");
    endtask : t_rates
    task automatic t_coll();
        wr(spims_pkg::ADDR_CTRL, 8'h50);
        wr(spims_pkg::ADDR_DATA, 8'h11);
        wr(spims_pkg::ADDR_DATA, 8'h22);
        wait_done();
        chk("collision", 8'hC0, rd_val);
        rd(spims_pkg::ADDR_DATA);
        rd(spims_pkg::ADDR_STATUS);
        chk("both cleared", 8'h00, rd_val);
        $display("test collision done");
    endtask : t_coll
    task automatic t_irq();
        int n;
        @(posedge i_clk);
        i_gie <= 1'b1;
        wr(spims_pkg::ADDR_CTRL, 8'hD0);
        wr(spims_pkg::ADDR_DATA, 8'h5A);
        n = 0;
        while (o_irq !== 1'b1 && n < 200) begin
            @(posedge i_clk);
            #1 n++;
        end
        chk("irq raised", 8'h01, {7'h00, o_irq});
        @(posedge i_clk);
        i_irq_ack <= 1'b1;
        @(posedge i_clk);
        i_irq_ack <= 1'b0;
        i_gie     <= 1'b0;
        rd(spims_pkg::ADDR_STATUS);
        chk("vector clear", 8'h00, rd_val);
        chk("irq dropped", 8'h00, {7'h00, o_irq});
        $display("test interrupt done");
    endtask : t_irq
    task automatic t_fault();
        wr(spims_pkg::ADDR_CTRL, 8'h50);
        @(posedge i_clk);
        i_ss_is_input <= 1'b1;
        i_ss_n        <= 1'b0;
        rd(spims_pkg::ADDR_CTRL);
        rd(spims_pkg::ADDR_CTRL);
        chk("master dropped", 8'h40, rd_val);
        chk("sck released", 8'h00, {7'h00, o_sck_oe});
        chk("mosi released", 8'h00, {7'h00, o_mosi_oe});
        rd(spims_pkg::ADDR_STATUS);
        chk("fault done", 8'h80, rd_val);
        rd(spims_pkg::ADDR_DATA);
        @(posedge i_clk);
        i_ss_n        <= 1'b1;
        i_ss_is_input <= 1'b0;
        $display("test fault done");
    endtask : t_fault
    task automatic t_slave();
        wr(spims_pkg::ADDR_CTRL, 8'h43);
        @(posedge i_clk);
        i_ss_n <= 1'b0;
        s_bits(8'hFF, 3);
        @(posedge i_clk);
        i_ss_n <= 1'b1;
        @(posedge i_clk);
        i_ss_n <= 1'b0;
        wr(spims_pkg::ADDR_DATA, 8'h3C);
        chk("miso enable", 8'h01, {7'h00, o_miso_oe});
        s_bits(8'hA5, 8);
        wait_done();
        chk("slave tx", 8'h3C, s_got);
        rd(spims_pkg::ADDR_DATA);
        chk("slave rx", 8'hA5, rd_val);
        @(posedge i_clk);
        i_ss_n <= 1'b1;
        $display("test slave done");
    endtask : t_slave
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : final_report
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            final_report();
        end
    end
    initial begin
        repeat (20) @(posedge i_clk);
        i_srst <= 1'b0;
        t_regs();
        t_modes();
        t_rates();
        t_coll();
        t_irq();
        t_fault();
        t_slave();
        final_report();
    end
endmodule : tb_spi_master_slave_port
